//--- cfg_guard_consts.vh
// Constants for the switch monitor configuration guard
`ifndef CFG_GUARD_CONSTS_VH
`define CFG_GUARD_CONSTS_VH
// Software register indices
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_CONFIG 4'h2
`define REG_IN_EN 4'h3
`define REG_MODE 4'h4
`define REG_CS_SELECT 4'h5
`define REG_WC_LOW 4'h6
`define REG_WC_HIGH 4'h7
`define REG_CLEAN_POLL 4'h8
`define REG_SCALE 4'h9
// Device register addresses
`define DEV_CONFIG 4'h0
`define DEV_IN_EN 4'h1
`define DEV_MODE 4'h2
`define DEV_CS_SELECT 4'h3
`define DEV_WC_LOW 4'h4
`define DEV_WC_HIGH 4'h5
`define DEV_CLEAN_POLL 4'h6
`define DEV_LAST 4'h6
// Control register bits
`define CTRL_TEMP_WARN 0
`define CTRL_COMMIT 1
// Status register bits
`define ST_BUSY 0
`define ST_REJECT 1
`define ST_SCALE_POLL 2
`define ST_VIOL_LSB 8
// Device config fields
`define CFG_POLL_EN 0
`define CFG_GRID_LSB 3
`define CFG_VS_MEAS 16
`define CFG_DIAG_LSB 18
`define WC_SCALE_LSB 21
// Grid size and scaling codes
`define GRID_5X5 2'b10
`define GRID_6X6 2'b11
`define SCALE_OFF 2'b11
// Reset values
`define RST_CFG 24'h000000
`define RST_WC_HIGH 24'h600000
`endif

//--- cfg_guard.v
// Host controller that vets and pushes switch monitor configuration
`timescale 1ns/1ps
`include "cfg_guard_consts.vh"
// Operation
// - 5x5 grid needs periodic sampling and inputs 8..4, 14..10 enabled.
// - 5x5 grid needs inputs 8..4 and 14..10 in comparator mode.
// - 5x5 grid: inputs 8..4 source current, inputs 14..10 sink current.
// - 6x6 grid needs periodic sampling and inputs 9..4, 15..10 enabled.
// - 6x6 grid needs inputs 9..4 and 15..10 in comparator mode.
// - 6x6 grid: inputs 9..4 source current, inputs 15..10 sink current.
// - Grid scanning: sink wetting codes must exceed paired source codes.
// - With grid scanning and temperature warning expected, sink 1 or 2 mA with allowed source code.
// - Clean polling needs an enabled input or supply measurement enabled.
// - Current diagnostic needs at least one of inputs 0..3 enabled.
// - Current diagnostic needs inputs 0..3 in analog conversion mode.
// - Current diagnostic needs inputs 0 and 1 on sink current.
// - Current diagnostic needs inputs 2 and 3 on source current.
module cfg_guard #(
  parameter NUM_CODES = 14
) (
  input wire CLK,
  input wire RST,
  input wire [3:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  output reg DEV_WR,
  output reg [3:0] DEV_ADDR,
  output reg [23:0] DEV_WDATA,
  output reg BUSY,
  output reg CFG_ERROR
);
  reg temp_warn_q;
  reg [23:0] config_q;
  reg [23:0] in_en_q;
  reg [23:0] mode_q;
  reg [23:0] cs_q;
  reg [23:0] wc_low_q;
  reg [23:0] wc_high_q;
  reg [23:0] clean_q;
  reg [3:0] idx_q;
  reg [16:0] viol;
  reg [1:0] grid;
  reg grid_on;
  reg poll_en;
  reg diag_on;
  reg scale_req;
  reg scale_poll;
  reg [23:0] dev_data;
  reg [31:0] rd_d;
  wire [47:0] codes;
  wire [NUM_CODES-1:0] scale_mask;
  wire commit;
  wire [2:0] snk0;
  wire [2:0] snk1;
  wire [2:0] snk2;
  wire [2:0] snk3;
  wire [2:0] src0;
  wire [2:0] src1;
  wire [2:0] src2;
  wire [2:0] src3;

  assign codes = {wc_high_q, wc_low_q};
  assign commit = WR && (ADDR == `REG_CTRL) && WDATA[`CTRL_COMMIT] && !BUSY;
  // Sink and paired source codes
  assign snk0 = wc_low_q[8:6];
  assign src0 = wc_low_q[20:18];
  assign snk1 = wc_low_q[11:9];
  assign src1 = wc_low_q[23:21];
  assign snk2 = wc_high_q[2:0];
  assign src2 = wc_low_q[14:12];
  assign snk3 = wc_high_q[5:3];
  assign src3 = wc_low_q[17:15];

  function tw_bad;
    input [2:0] snk;
    input [2:0] src;
    begin
      tw_bad = 1'b1;
      if (snk == 3'h1) begin
        tw_bad = (src < 3'h2);
      end else if (snk == 3'h2) begin
        tw_bad = (src != 3'h3);
      end
    end
  endfunction

  // Per-input auto-scaling applicability
  genvar g;
  generate
    for (g = 0; g < NUM_CODES; g = g + 1) begin : g_scale
      assign scale_mask[g] = scale_req && !poll_en && codes[3*g+2];
    end
  endgenerate

  // Legality evaluation
  always @* begin
    grid = config_q[`CFG_GRID_LSB+1:`CFG_GRID_LSB];
    poll_en = config_q[`CFG_POLL_EN];
    grid_on = (grid == `GRID_5X5) || (grid == `GRID_6X6);
    diag_on = (config_q[`CFG_DIAG_LSB+3:`CFG_DIAG_LSB] != 4'h0);
    scale_req = (wc_high_q[`WC_SCALE_LSB+1:`WC_SCALE_LSB] != `SCALE_OFF);
    scale_poll = scale_req && poll_en;
    viol = 17'h00000;
    if (grid == `GRID_5X5) begin
      viol[0] = !poll_en || (in_en_q[8:4] != 5'h1f) || (in_en_q[14:10] != 5'h1f);
      viol[1] = (mode_q[8:4] != 5'h00) || (mode_q[14:10] != 5'h00);
      viol[2] = (cs_q[8:4] != 5'h1f) || (cs_q[14:10] != 5'h00);
    end
    if (grid == `GRID_6X6) begin
      viol[3] = !poll_en || (in_en_q[9:4] != 6'h3f) || (in_en_q[15:10] != 6'h3f);
      viol[4] = (mode_q[9:4] != 6'h00) || (mode_q[15:10] != 6'h00);
      viol[5] = (cs_q[9:4] != 6'h3f) || (cs_q[15:10] != 6'h00);
    end
    if (grid_on) begin
      viol[6] = !(src0 < snk0);
      viol[7] = !(src1 < snk1);
      viol[8] = !(snk2 > src2);
      viol[9] = !(snk3 > src3);
      if (temp_warn_q) begin
        viol[10] = tw_bad(snk0, src0) || tw_bad(snk1, src1);
        viol[11] = tw_bad(snk2, src2) || tw_bad(snk3, src3);
      end
    end
    viol[12] = (clean_q != 24'h000000) && (in_en_q == 24'h000000)
      && !config_q[`CFG_VS_MEAS];
    if (diag_on) begin
      viol[13] = (in_en_q[3:0] == 4'h0);
      viol[14] = (mode_q[3:0] != 4'hf);
      viol[15] = (cs_q[1:0] != 2'h0);
      viol[16] = (cs_q[3:2] != 2'h3);
    end
  end

  // Device register selection for the push sequence
  always @* begin
    case (idx_q)
      `DEV_CONFIG: dev_data = config_q;
      `DEV_IN_EN: dev_data = in_en_q;
      `DEV_MODE: dev_data = mode_q;
      `DEV_CS_SELECT: dev_data = cs_q;
      `DEV_WC_LOW: dev_data = wc_low_q;
      `DEV_WC_HIGH: dev_data = wc_high_q;
      `DEV_CLEAN_POLL: dev_data = clean_q;
      default: dev_data = 24'h000000;
    endcase
  end

  // Shadow registers, locked while a push runs
  always @(posedge CLK) begin
    if (RST) begin
      temp_warn_q <= 1'b0;
      config_q <= `RST_CFG;
      in_en_q <= `RST_CFG;
      mode_q <= `RST_CFG;
      cs_q <= `RST_CFG;
      wc_low_q <= `RST_CFG;
      wc_high_q <= `RST_WC_HIGH;
      clean_q <= `RST_CFG;
    end else if (WR && !BUSY) begin
      case (ADDR)
        `REG_CTRL: temp_warn_q <= WDATA[`CTRL_TEMP_WARN];
        `REG_CONFIG: config_q <= WDATA[23:0];
        `REG_IN_EN: in_en_q <= WDATA[23:0];
        `REG_MODE: mode_q <= WDATA[23:0];
        `REG_CS_SELECT: cs_q <= WDATA[23:0];
        `REG_WC_LOW: wc_low_q <= WDATA[23:0];
        `REG_WC_HIGH: wc_high_q <= WDATA[23:0];
        `REG_CLEAN_POLL: clean_q <= WDATA[23:0];
        default: temp_warn_q <= temp_warn_q;
      endcase
    end
  end

  // Commit: reject illegal sets, else push all device registers
  always @(posedge CLK) begin
    if (RST) begin
      BUSY <= 1'b0;
      CFG_ERROR <= 1'b0;
      idx_q <= 4'h0;
      DEV_WR <= 1'b0;
      DEV_ADDR <= 4'h0;
      DEV_WDATA <= 24'h000000;
    end else begin
      DEV_WR <= 1'b0;
      if (commit && (viol != 17'h00000)) begin
        CFG_ERROR <= 1'b1;
      end else if (commit) begin
        CFG_ERROR <= 1'b0;
        BUSY <= 1'b1;
        idx_q <= `DEV_CONFIG;
      end else if (WR && (ADDR == `REG_STATUS) && WDATA[`ST_REJECT]) begin
        CFG_ERROR <= 1'b0;
      end
      if (BUSY) begin
        DEV_WR <= 1'b1;
        DEV_ADDR <= idx_q;
        DEV_WDATA <= dev_data;
        idx_q <= idx_q + 4'h1;
        if (idx_q == `DEV_LAST) begin
          BUSY <= 1'b0;
        end
      end
    end
  end

  // Read data, one cycle after the strobe
  always @* begin
    rd_d = 32'h00000000;
    case (ADDR)
      `REG_CTRL: rd_d[`CTRL_TEMP_WARN] = temp_warn_q;
      `REG_STATUS: begin
        rd_d[`ST_BUSY] = BUSY;
        rd_d[`ST_REJECT] = CFG_ERROR;
        rd_d[`ST_SCALE_POLL] = scale_poll;
        rd_d[`ST_VIOL_LSB+16:`ST_VIOL_LSB] = viol;
      end
      `REG_CONFIG: rd_d[23:0] = config_q;
      `REG_IN_EN: rd_d[23:0] = in_en_q;
      `REG_MODE: rd_d[23:0] = mode_q;
      `REG_CS_SELECT: rd_d[23:0] = cs_q;
      `REG_WC_LOW: rd_d[23:0] = wc_low_q;
      `REG_WC_HIGH: rd_d[23:0] = wc_high_q;
      `REG_CLEAN_POLL: rd_d[23:0] = clean_q;
      `REG_SCALE: rd_d[NUM_CODES-1:0] = scale_mask;
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      RDATA <= rd_d;
    end else begin
      RDATA <= 32'h00000000;
    end
  end
endmodule // cfg_guard

//--- cfg_guard_sva.sv
// Checker for the configuration guard ports
`timescale 1ns/1ps
module cfg_guard_sva (
  input wire CLK,
  input wire RST,
  input wire [3:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [31:0] RDATA,
  input wire DEV_WR,
  input wire [3:0] DEV_ADDR,
  input wire BUSY,
  input wire CFG_ERROR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire commit = WR && ADDR == 4'h0 && WDATA[1] && !BUSY;
  a_commit_answer: assert property (commit |=> BUSY != CFG_ERROR)
    else $error("commit unanswered");
  a_push_start: assert property ($rose(BUSY) |-> !DEV_WR ##1 DEV_WR && DEV_ADDR == 4'h0)
    else $error("push start wrong");
  a_push_order: assert property (DEV_WR && DEV_ADDR != 4'h6 |=>
    DEV_WR && DEV_ADDR == $past(DEV_ADDR) + 4'h1) else $error("push order wrong");
  a_busy_len: assert property ($rose(BUSY) |-> BUSY [*7] ##1 !BUSY)
    else $error("busy length wrong");
  a_reject_quiet: assert property (commit ##1 CFG_ERROR |-> !BUSY ##1 !DEV_WR)
    else $error("rejected config pushed");
  a_write_in_push: assert property (DEV_WR |-> BUSY || DEV_ADDR == 4'h6)
    else $error("stray device write");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero");
  a_error_sticky: assert property (CFG_ERROR && !WR |=> CFG_ERROR)
    else $error("error flag dropped");
  cover property ($rose(BUSY));
  cover property ($rose(CFG_ERROR));
  cover property (DEV_WR && DEV_ADDR == 4'h6);
endmodule // cfg_guard_sva
bind cfg_guard cfg_guard_sva i_cfg_guard_sva (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .DEV_WR(DEV_WR), .DEV_ADDR(DEV_ADDR), .BUSY(BUSY),
  .CFG_ERROR(CFG_ERROR));

//--- dev_model.sv
// Behavioural model of the switch monitor register file
`timescale 1ns/1ps
module dev_model (
  input wire clk,
  input wire wr,
  input wire [3:0] addr,
  input wire [23:0] wdata
);
  reg [23:0] regs_q [0:6];
  reg [7:0] scale_in;
  integer i;
  wire scale_on = regs_q[5][22:21] != 2'b11 && !regs_q[0][0];
  wire [3:0] adc_in = regs_q[2][3:0];
  always @* begin
    for (i = 0; i < 8; i = i + 1) scale_in[i] = scale_on && regs_q[4][3*i+2];
  end
  always @(posedge clk) begin
    if (wr && addr <= 4'h6) regs_q[addr] <= wdata;
  end
endmodule // dev_model

//--- tb_top.sv
// Self-checking bench for the configuration guard
`timescale 1ns/1ps
`include "cfg_guard_consts.vh"
module tb_top;
  reg CLK = 0, RST = 1, WR = 0, RD = 0;
  reg [3:0] ADDR = 4'h0;
  reg [31:0] WDATA = 32'h0;
  wire [31:0] RDATA;
  wire DEV_WR, BUSY, CFG_ERROR;
  wire [3:0] DEV_ADDR;
  wire [23:0] DEV_WDATA;
  integer n_mismatch = 0, tests_run = 0, seed = 32'ha5c6c312, k, j;
  reg [31:0] r, cf, en, md, cs;
  cfg_guard i_cfg_guard (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .DEV_WR(DEV_WR), .DEV_ADDR(DEV_ADDR), .DEV_WDATA(DEV_WDATA), .BUSY(BUSY),
    .CFG_ERROR(CFG_ERROR));
  dev_model i_dev_model (.clk(CLK), .wr(DEV_WR), .addr(DEV_ADDR), .wdata(DEV_WDATA));
  initial forever #12.5 CLK = ~CLK;
  function legal_diag(input [31:0] c, e, m, s);
    legal_diag = c[21:18] == 4'h0 || (e[3:0] != 4'h0 && m[3:0] == 4'hf && s[3:0] == 4'hc);
  endfunction
  task summarize;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 chk("rdata", e, RDATA);
    end
  endtask
  task set(input [31:0] c, e, m, s);
    begin
      wr(`REG_CONFIG, c);
      wr(`REG_IN_EN, e);
      wr(`REG_MODE, m);
      wr(`REG_CS_SELECT, s);
    end
  endtask
  task commit(input [31:0] ctl, input ok);
    begin
      wr(`REG_CTRL, ctl & 32'h1);
      wr(`REG_CTRL, ctl);
      #1;
      for (k = 0; k < 20 && BUSY !== 1'b0; k = k + 1) @(posedge CLK) #1;
      if (k == 20) begin
        n_mismatch = n_mismatch + 1;
        summarize;
      end
      chk("cfg_err", {31'h0, !ok}, {31'h0, CFG_ERROR});
    end
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    rd(`REG_WC_HIGH, 32'h600000);
    rd(4'hf, 32'h0);
    set(32'h11, 32'h7df0, 32'h0, 32'h1f0);
    wr(`REG_WC_LOW, 32'h240480);
    wr(`REG_WC_HIGH, 32'h600009);
    rd(`REG_CONFIG, 32'h11);
    commit(32'h2, 1'b1);
    chk("dev_en", 32'h7df0, {8'h0, i_dev_model.regs_q[1]});
    commit(32'h3, 1'b0);
    wr(`REG_MODE, 32'h10);
    commit(32'h2, 1'b0);
    set(32'h11, 32'h7df0, 32'h0, 32'h5f0);
    commit(32'h2, 1'b0);
    set(32'h19, 32'hfff0, 32'h0, 32'h3f0);
    commit(32'h2, 1'b1);
    wr(`REG_IN_EN, 32'hfef0);
    commit(32'h2, 1'b0);
    wr(`REG_IN_EN, 32'hfff0);
    wr(`REG_WC_LOW, 32'h280480);
    commit(32'h2, 1'b0);
    set(32'h0, 32'h0, 32'h0, 32'h0);
    wr(`REG_CLEAN_POLL, 32'h1);
    commit(32'h2, 1'b0);
    wr(`REG_STATUS, 32'h2);
    rd(`REG_STATUS, 32'h100000);
    wr(`REG_CONFIG, 32'h10000);
    commit(32'h2, 1'b1);
    wr(`REG_CLEAN_POLL, 32'h0);
    wr(`REG_WC_HIGH, 32'h24);
    rd(`REG_SCALE, 32'h300);
    wr(`REG_CONFIG, 32'h1);
    rd(`REG_SCALE, 32'h0);
    rd(`REG_STATUS, 32'h4);
    for (j = 0; j < 12; j = j + 1) begin
      r = $random(seed);
      cf = {10'h0, r[3:0], 18'h0};
      en = {28'h0, r[11:8]};
      md = r[5] ? 32'hf : {28'h0, r[15:12]};
      cs = r[5] ? 32'hc : {28'h0, r[19:16]};
      set(cf, en, md, cs);
      commit(32'h2, legal_diag(cf, en, md, cs));
    end
    summarize;
  end
endmodule // tb_top
